// *** verilog/dsc_pkg.sv ***
// Package for the DMA channel sizing and destination stepping block.
// Assumes a 32-bit APB register bus with word-aligned registers.
package dsc_pkg;

    // Register byte offsets
    localparam logic [7:0] DSC_OFS_CTRL = 8'h00;
    localparam logic [7:0] DSC_OFS_DEST = 8'h04;
    localparam logic [7:0] DSC_OFS_MODE = 8'h08;
    localparam logic [7:0] DSC_OFS_STAT = 8'h0C;
    localparam logic [7:0] DSC_OFS_CMD = 8'h10;

    // Control field positions
    localparam int DSC_POS_PORT = 0;
    localparam int DSC_POS_SIZE = 2;
    localparam int DSC_POS_STEP = 4;
    localparam int DSC_POS_DIO = 6;
    localparam int DSC_POS_SIO = 9;

    // Status and command bit positions
    localparam int DSC_POS_READY = 31;
    localparam int DSC_POS_CONF = 18;
    localparam int DSC_POS_GO = 0;
    localparam int DSC_POS_STOP = 1;

    // Reset values
    localparam logic [1:0] DSC_RST_FIELD2 = 2'h0;
    localparam logic DSC_RST_BIT = 1'h0;
    localparam logic [31:0] DSC_RST_ADDR = 32'h0000_0000;

    // Byte counts for a request or port of each width
    localparam logic [2:0] DSC_BYTES_1 = 3'h1;
    localparam logic [2:0] DSC_BYTES_2 = 3'h2;
    localparam logic [2:0] DSC_BYTES_4 = 3'h4;

    typedef enum logic [1:0] {
        DSC_STEP_INC,
        DSC_STEP_DEC,
        DSC_STEP_HOLD
    } dsc_step_t;

    // Shared decode of the two width fields: 11 byte, 10 half, 0x word
    function automatic logic [2:0] dsc_width_bytes(input logic [1:0] code);
        logic [2:0] res;
        res = DSC_BYTES_4;
        if (code == 2'h3)
            res = DSC_BYTES_1;
        else if (code == 2'h2)
            res = DSC_BYTES_2;
        return res;
    endfunction : dsc_width_bytes

endpackage : dsc_pkg

// *** verilog/dsc_addr_step.sv ***
// Destination address register with load and per-cycle stepping.
// Assumes step and load come from the same clock and never coincide
// with an ambiguous intent: load wins over a step.
`timescale 1ns/1ps
module dsc_addr_step
    import dsc_pkg::*;
#(
    parameter int AW = 32
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [AW-1:0] loadValue,
    input wire logic step,
    input wire dsc_step_t stepMode,
    input wire logic [2:0] stepBytes,
    output logic [AW-1:0] addr
);

    logic [AW-1:0] addr_r;
    logic [AW-1:0] addr_nxt;
    logic [AW-1:0] delta;

    assign delta = {{(AW-3){1'b0}}, stepBytes};

    // Next address from the stepping mode and the request size
    always_comb
    begin
        addr_nxt = addr_r;
        case (stepMode)
            DSC_STEP_INC: addr_nxt = addr_r + delta;
            DSC_STEP_DEC: addr_nxt = addr_r - delta;
            DSC_STEP_HOLD: addr_nxt = addr_r;
            default: addr_nxt = addr_r;
        endcase
    end

    // Address register; software load overrides a step
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            addr_r <= DSC_RST_ADDR[AW-1:0];
        else if (load)
            addr_r <= loadValue;
        else if (step)
            addr_r <= addr_nxt;
    end

    assign addr = addr_r;

endmodule : dsc_addr_step

// *** verilog/dsc_channel.sv ***
// DMA channel sizing and destination stepping, with its APB registers.
// Assumes cycleDone and xferEnd are one-cycle pulses from the channel's
// own sequencer on clk_sys; no synchroniser is needed for them.
//
// Behaviour
// - Destination steps: 00 up, 01 down, 1x hold.
// - Request size: 11 byte, 10 half, 0x word.
// - I/O port width: 11 byte, 10 half, 0x word.
// - Port width ignored for memory-to-memory transfers.
// - Destination type bit: 1 I/O, 0 memory.
// - Destination step from step, size and address mode.
// - Read-only ready bit, 1 when ready, resets 0.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module dsc_channel
    import dsc_pkg::*;
#(
    parameter int AW = 32
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cycleDone,
    input wire logic xferEnd,
    output logic [AW-1:0] destAddr,
    output logic [2:0] xferBytes,
    output logic [2:0] ioPortBytes,
    output logic ioPortUsed,
    output logic destIsIo,
    output logic channelReady
);

    // Control fields as programmed
    logic [1:0] destStep_r;
    logic [1:0] xferWidth_r;
    logic [1:0] ioPortWidth_r;
    logic destIsIoCfg_r;
    logic srcIsIo_r;
    logic destModeHold_r;
    logic ready_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [2:0] xferBytes_r;
    logic [2:0] ioPortBytes_r;
    logic ioPortUsed_r;
    logic destIsIo_r;
    dsc_step_t stepMode_r;
    logic [AW-1:0] addrNow;
    logic [AW-1:0] destAddr_r;
    logic [31:0] readMux;
    logic [31:0] ctrlWord;
    logic mapped;
    logic wrTake;
    logic cfgMismatch;
    logic goReq;
    logic stopReq;
    logic destLoad;

    // Access phase ends when our registered pready is seen high
    assign wrTake = psel && penable && pready_r && pwrite;
    assign mapped = (paddr == DSC_OFS_CTRL) || (paddr == DSC_OFS_DEST) ||
                    (paddr == DSC_OFS_MODE) || (paddr == DSC_OFS_STAT) ||
                    (paddr == DSC_OFS_CMD);
    assign goReq = wrTake && (paddr == DSC_OFS_CMD) && pwdata[DSC_POS_GO];
    assign stopReq = wrTake && (paddr == DSC_OFS_CMD) &&
                     pwdata[DSC_POS_STOP];
    // Address reload only while idle, so a live transfer is not disturbed
    assign destLoad = wrTake && (paddr == DSC_OFS_DEST) && !ready_r;

    // Advisory flag: I/O transfer whose size differs from the port width
    assign cfgMismatch = (destIsIoCfg_r || srcIsIo_r) &&
        (dsc_width_bytes(xferWidth_r) != dsc_width_bytes(ioPortWidth_r));

    // Control register; writes are ignored while the channel is ready,
    // so settings must be complete before going ready
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            destStep_r <= DSC_RST_FIELD2;
            xferWidth_r <= DSC_RST_FIELD2;
            ioPortWidth_r <= DSC_RST_FIELD2;
            destIsIoCfg_r <= DSC_RST_BIT;
            srcIsIo_r <= DSC_RST_BIT;
        end
        else if (wrTake && (paddr == DSC_OFS_CTRL) && !ready_r)
        begin
            destStep_r <= pwdata[DSC_POS_STEP +: 2];
            xferWidth_r <= pwdata[DSC_POS_SIZE +: 2];
            ioPortWidth_r <= pwdata[DSC_POS_PORT +: 2];
            destIsIoCfg_r <= pwdata[DSC_POS_DIO];
            srcIsIo_r <= pwdata[DSC_POS_SIO];
        end
    end

    // Destination address mode; 1 freezes the address regardless
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            destModeHold_r <= DSC_RST_BIT;
        else if (wrTake && (paddr == DSC_OFS_MODE) && !ready_r)
            destModeHold_r <= pwdata[0];
    end

    // Ready state: go sets, stop or end of transfer clears; go wins
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ready_r <= DSC_RST_BIT;
        else if (goReq)
            ready_r <= 1'b1;
        else if (stopReq || xferEnd)
            ready_r <= 1'b0;
    end

    // Effective settings, captured as the channel goes ready
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            xferBytes_r <= DSC_BYTES_4;
            ioPortBytes_r <= DSC_BYTES_4;
            ioPortUsed_r <= DSC_RST_BIT;
            destIsIo_r <= DSC_RST_BIT;
            stepMode_r <= DSC_STEP_INC;
        end
        else if (goReq && !ready_r)
        begin
            xferBytes_r <= dsc_width_bytes(xferWidth_r);
            ioPortBytes_r <= dsc_width_bytes(ioPortWidth_r);
            // Memory to memory: the port width is still captured but flagged unused
            ioPortUsed_r <= destIsIoCfg_r || srcIsIo_r;
            destIsIo_r <= destIsIoCfg_r;
            if (destModeHold_r || destStep_r[1])
                stepMode_r <= DSC_STEP_HOLD;
            else if (destStep_r[0])
                stepMode_r <= DSC_STEP_DEC;
            else
                stepMode_r <= DSC_STEP_INC;
        end
    end

    // Address stepper; it moves only on cycles of a ready channel
    dsc_addr_step #(
        .AW(AW)
    ) u_step (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(destLoad),
        .loadValue(pwdata[AW-1:0]),
        .step(cycleDone && ready_r),
        .stepMode(stepMode_r),
        .stepBytes(xferBytes_r),
        .addr(addrNow)
    );

    // Registered copy so the output comes straight from a flop
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            destAddr_r <= DSC_RST_ADDR[AW-1:0];
        else
            destAddr_r <= addrNow;
    end

    assign ctrlWord = {22'h000000, srcIsIo_r, 2'h0, destIsIoCfg_r,
                       destStep_r, xferWidth_r, ioPortWidth_r};

    // Read data selection; unmapped and command reads give zero
    always_comb
    begin
        readMux = 32'h0000_0000;
        case (paddr)
            DSC_OFS_CTRL: readMux = ctrlWord;
            DSC_OFS_DEST: readMux = 32'(addrNow);
            DSC_OFS_MODE: readMux = {31'h0000_0000, destModeHold_r};
            DSC_OFS_STAT:
            begin
                readMux[DSC_POS_READY] = ready_r;
                readMux[DSC_POS_CONF] = cfgMismatch;
            end
            default: readMux = 32'h0000_0000;
        endcase
    end

    // APB answer: one wait state, so pready and prdata are registered
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (psel && penable && !pready_r)
        begin
            pready_r <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r <= pwrite ? 32'h0000_0000 : readMux;
        end
        else
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign destAddr = destAddr_r;
    assign xferBytes = xferBytes_r;
    assign ioPortBytes = ioPortBytes_r;
    assign ioPortUsed = ioPortUsed_r;
    assign destIsIo = destIsIo_r;
    assign channelReady = ready_r;

endmodule : dsc_channel

// *** testbench/dsc_chk.sv ***
// Port checker for dsc_channel, one clock domain.
// Bound from the bench; sees only the top module's ports.
`timescale 1ns/1ps
module dsc_chk
    import dsc_pkg::*;
#(parameter int AW = 32)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cycleDone,
    input wire logic xferEnd,
    input wire logic [AW-1:0] destAddr,
    input wire logic [2:0] xferBytes,
    input wire logic [2:0] ioPortBytes,
    input wire logic ioPortUsed,
    input wire logic destIsIo,
    input wire logic channelReady
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic [AW-1:0] xb;
    // Step size widened to the address
    assign xb = AW'(xferBytes);
    AST_ONE_WAIT: assert property (psel && penable && !pready
        |=> pready ##1 !pready) else $error("pready timing");
    AST_ERR_ZERO: assert property (pslverr && !pwrite
        |-> pready && prdata == 32'h0) else $error("error read");
    AST_XB_CODE: assert property (xb == 1 || xb == 2 || xb == 4)
        else $error("request size code");
    AST_PB_CODE: assert property (
        ioPortBytes inside {3'h1, 3'h2, 3'h4}) else $error("port width code");
    AST_MEM_USE: assert property (!ioPortUsed |-> !destIsIo)
        else $error("mem end flagged io");
    AST_LATCH: assert property (channelReady
        && $past(channelReady) |-> $stable(destIsIo) && $stable(xferBytes))
        else $error("latch");
    AST_KEEP_RDY: assert property (channelReady && !xferEnd
        && !psel |=> channelReady) else $error("ready dropped");
    // destAddr trails the internal address by one edge
    AST_NO_STEP: assert property (channelReady && !cycleDone
        |=> ##1 $stable(destAddr)) else $error("address moved");
    AST_STEP: assert property (channelReady && cycleDone
        |=> ##1 (destAddr - $past(destAddr) == xb
        || $past(destAddr) - destAddr == xb || $stable(destAddr)))
        else $error("address step");
endmodule : dsc_chk

// *** testbench/dsc_seq_model.sv ***
// Sequencer model: cycle pulses with a gap, then an end pulse.
// Gap 0 gives back-to-back cycles, larger gaps a slow far side.
`timescale 1ns/1ps
module dsc_seq_model
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic [3:0] count,
    input wire logic [3:0] gap,
    output logic cycleDone,
    output logic xferEnd
);
    logic [3:0] left_r;
    logic [3:0] wait_r;
    logic busy_r;
    // Pulses stand one cycle only
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            {cycleDone, xferEnd, busy_r, left_r, wait_r} <= '0;
        end
        else
        begin
            cycleDone <= 1'h0;
            xferEnd <= 1'h0;
            if (start)
                {busy_r, left_r, wait_r} <= {1'h1, count, gap};
            else if (busy_r && wait_r != 4'h0)
                wait_r <= wait_r - 4'h1;
            else if (busy_r && left_r != 4'h0)
                {cycleDone, left_r, wait_r} <= {1'h1, left_r - 4'h1, gap};
            else if (busy_r)
                {xferEnd, busy_r} <= 2'h2;
        end
    end
endmodule : dsc_seq_model

// *** testbench/tb_top.sv ***
// Bench for dsc_channel: APB master, integer address model.
// Drives on rising edges; the sequencer model pulses cycles.
`timescale 1ns/1ps
module tb_top
    import dsc_pkg::*;
;
    logic clk_sys = '0, rst = '1, psel = '0, penable = '0, pwrite = '0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, expA, destAddr, rnd = 32'h25;
    logic pready, pslverr, cycleDone, xferEnd, destIsIo, channelReady;
    logic ioPortUsed, er, start = '0;
    logic [2:0] xferBytes, ioPortBytes;
    logic [3:0] cnt = '0, gap = '0;
    int bad_count = 0, check_count = 0, cyc = 0;
    dsc_channel #(.AW(32)) DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cycleDone(cycleDone), .xferEnd(xferEnd), .destAddr(destAddr),
        .xferBytes(xferBytes), .ioPortBytes(ioPortBytes),
        .ioPortUsed(ioPortUsed), .destIsIo(destIsIo),
        .channelReady(channelReady));
    dsc_seq_model uSeq (.clk_sys(clk_sys), .rst(rst), .start(start),
        .count(cnt), .gap(gap), .cycleDone(cycleDone), .xferEnd(xferEnd));
    initial forever #50 clk_sys = ~clk_sys;
    // Hang guard, far above the expected run length
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            close_out();
        end
    end
    function automatic logic [2:0] wb(input logic [1:0] c);
        return c[1] ? (c[0] ? 3'h1 : 3'h2) : 3'h4;
    endfunction : wb
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        @(posedge clk_sys);
        while (pready !== 1'h1)
            @(posedge clk_sys);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // k: step code, size code, address mode; port and ends random
    task automatic run(input logic [4:0] k);
        logic [31:0] c;
        logic cf;
        rnd = lfsr(rnd);
        c = {22'h0, rnd[3], 2'h0, rnd[2], k[1:0], k[3:2], rnd[1:0]};
        cf = (c[6] | c[9]) && wb(k[3:2]) != wb(c[1:0]);
        expA = {rnd[31:8], 8'h80};
        cnt <= rnd[7:4];
        gap <= {2'h0, rnd[9:8]};
        apb(1'h1, DSC_OFS_CTRL, c);
        apb(1'h1, DSC_OFS_DEST, expA);
        apb(1'h1, DSC_OFS_MODE, {31'h0, k[4]});
        apb(1'h1, DSC_OFS_CMD, 32'h1);
        apb(1'h1, DSC_OFS_CTRL, ~c);
        apb(1'h0, DSC_OFS_CTRL, 32'h0);
        chk("ctrl", rd, c);
        apb(1'h0, DSC_OFS_STAT, 32'h0);
        chk("stat", rd, {1'h1, 12'h0, cf, 18'h0});
        chk("conf", 32'(rd[DSC_POS_CONF]), 32'(cf));
        chk("xb", 32'(xferBytes), 32'(wb(k[3:2])));
        chk("use", 32'(ioPortUsed), 32'(c[6] | c[9]));
        if (c[6] | c[9])
            chk("pb", 32'(ioPortBytes), 32'(wb(c[1:0])));
        chk("dio", 32'(destIsIo), 32'(c[6]));
        start <= 1'h1;
        @(posedge clk_sys);
        start <= 1'h0;
        if (!k[4] && !k[1])
            expA = k[0] ? expA - cnt * wb(k[3:2]) : expA + cnt * wb(k[3:2]);
        while (xferEnd !== 1'h1)
            @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        chk("addr", destAddr, expA);
        chk("done", 32'(channelReady), 32'h0);
        $display("test run %0d done", k);
    endtask : run
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    // Reset, defaults, every step, size and mode combination, unmapped access
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'h0;
        apb(1'h0, DSC_OFS_CTRL, 32'h0);
        chk("ctrl0", rd, 32'h0);
        apb(1'h0, DSC_OFS_STAT, 32'h0);
        chk("stat0", rd, 32'h0);
        chk("xb0", 32'(xferBytes), 32'h4);
        chk("pb0", 32'(ioPortBytes), 32'h4);
        chk("dio0", 32'(destIsIo), 32'h0);
        $display("test reset done");
        for (int k = 0; k < 32; k++)
            run(5'(k));
        apb(1'h0, 8'h14, 32'h0);
        chk("err", {er, rd[30:0]}, 32'h8000_0000);
        $display("test unmapped done");
        // Stop command clears ready without any transfer end
        apb(1'h1, DSC_OFS_CMD, 32'h1);
        apb(1'h0, DSC_OFS_STAT, 32'h0);
        chk("go", 32'(rd[DSC_POS_READY]), 32'h1);
        apb(1'h1, DSC_OFS_CMD, 32'h2);
        apb(1'h0, DSC_OFS_STAT, 32'h0);
        chk("stop", 32'(rd[DSC_POS_READY]), 32'h0);
        $display("test stop done");
        close_out();
    end
endmodule : tb_top
bind dsc_channel dsc_chk #(.AW(AW)) uChk (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cycleDone(cycleDone),
    .xferEnd(xferEnd), .destAddr(destAddr), .xferBytes(xferBytes),
    .ioPortBytes(ioPortBytes), .ioPortUsed(ioPortUsed),
    .destIsIo(destIsIo), .channelReady(channelReady));
